/* File: adc_output_config_bank.sv */
// Configuration bank for power, output, pattern, format and front-end settings
// Assumes sample stream from the converters and per-channel gain and offset
// Notes on behaviour
// - Standby bit set puts the device in fast-recovery standby.
// - Per-channel power-down bits sleep a channel; its output word is zero.
// - Output-disable bit set turns the data outputs off.
// - Global power-down bit set puts the chip in slow-recovery sleep.
// - Three-bit code selects normal, sync, deskew, custom, ones, toggle, zeros, ramp.
// - Averaging bit set outputs the mean of the current and previous samples.
// - Eight bits power down the eight output pairs individually.
// - Two-bit code sets serialization factor: 12x, 10x, 16x, 14x.
// - Digital gain applied only while its enable bit is set.
// - Offset subtracted only while its enable bit is set.
// - Format bit: zero two's complement, one offset binary.
// - Fourteen-bit custom word is sent while pattern code is 011.
// - Noise-mode bit: zero low power, one low noise.
// - Two-bit self-test code: 01 gives 100 mV, 11 gives 150 mV.
// - Self-test forces coupling select to one, restoring it afterwards.
// - Two-bit filter corner select: 14, 10, 7.5 MHz; 11 unused.
// - Write word is 8 address bits then 16 data; tail dropped.
// - Hardware pin or self-clearing software bit zeroes every configuration register; the sample path registers are not reset.
`timescale 1ns/100ps
`default_nettype none
`include "adc_cfg_defs.svh"

module adc_output_config_bank (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         srst,
   // Serial programming pins
   input  wire logic         hw_reset_pin,
   input  wire logic         serial_clk,
   input  wire logic         serial_select_n,
   input  wire logic         serial_in,
   // Converter sample stream
   input  wire logic         sample_valid,
   input  wire logic [2:0]   sample_chan,
   input  wire logic [11:0]  sample_data,
   input  wire logic [4:0]   gain_code,
   input  wire logic [7:0]   offset_value,
   // Power, analog, bank and serializer controls
   output logic              quick_sleep,
   output logic [7:0]        lane_sleep_mask,
   output logic              chip_sleep,
   output logic              curve_bank_select,
   output logic              low_noise_mode,
   output logic [1:0]        self_test_level,
   output logic [1:0]        antialias_corner_select,
   output logic              coupling_select,
   output logic [1:0]        serializer_factor,
   output logic [4:0]        bits_per_sample,
   // Serial data lanes
   output logic              lane_valid,
   output logic [2:0]        lane_chan,
   output logic [13:0]       lane_word,
   output logic [7:0]        lane_pair_enable
);

   logic                        wr_valid;
   logic [`ADDR_BITS-1:0]       wr_addr;
   logic [`DATA_BITS-1:0]       wr_data;
   logic [2:0]                  rst_sync;
   logic                        hw_rst_filt;
   logic                        soft_rst;
   logic                        bank_rst;
   logic                        gp_write;
   logic                        output_disable;
   adc_cfg_pkg::pattern_mode_t  pattern_mode;
   logic                        average_enable;
   logic [7:0]                  output_pair_sleep_mask;
   logic                        gain_enable;
   logic                        offset_enable;
   logic                        number_coding_select;
   logic [13:0]                 user_word;
   logic                        coupling_stored;
   logic signed [13:0]          held_sample;
   logic [13:0]                 ramp_count;
   logic                        toggle_phase;
   logic signed [13:0]          v_offset;
   logic signed [20:0]          v_gain_full;
   logic signed [13:0]          v_gain;
   logic signed [14:0]          v_avg;
   logic [11:0]                 v_sat;
   logic [13:0]                 normal_word;
   logic [13:0]                 next_lane_word;

   serial_write_rx u_rx (
      .clk             (clk),
      .srst            (srst),
      .serial_clk      (serial_clk),
      .serial_select_n (serial_select_n),
      .serial_in       (serial_in),
      .wr_valid        (wr_valid),
      .wr_addr         (wr_addr),
      .wr_data         (wr_data)
   );

   // Reset pin is asynchronous to clk
   always_ff @(posedge clk) begin
      if (srst) begin
         rst_sync    <= 3'h0;
         hw_rst_filt <= 1'b0;
      end else begin
         rst_sync <= {rst_sync[1:0], hw_reset_pin};
         if (rst_sync[1] == rst_sync[2]) begin
            hw_rst_filt <= rst_sync[2];
         end
      end
   end

   // Software reset lasts one cycle, then the bit reads back as zero
   always_ff @(posedge clk) begin
      if (srst) begin
         soft_rst <= 1'b0;
      end else begin
         soft_rst <= wr_valid && (wr_addr == `ADDR_BANK_CTRL)
                     && wr_data[`BIT_SOFT_RESET] && !soft_rst;
      end
   end

   assign bank_rst = srst | hw_rst_filt | soft_rst;
   // Writes to shared addresses are ignored while the curve bank is selected
   assign gp_write = wr_valid && !curve_bank_select;

   always_ff @(posedge clk) begin
      if (bank_rst) begin
         curve_bank_select <= 1'b0;
      end else if (wr_valid && wr_addr == `ADDR_BANK_CTRL) begin
         curve_bank_select <= wr_data[`BIT_CURVE_BANK];
      end
   end

   // Unused bits are not stored, so written ones there have no effect
   always_ff @(posedge clk) begin
      if (bank_rst) begin
         quick_sleep     <= 1'b0;
         lane_sleep_mask <= `RST_LANE_MASK;
         output_disable  <= 1'b0;
         chip_sleep      <= 1'b0;
      end else if (gp_write && wr_addr == `ADDR_POWER_OUT) begin
         quick_sleep     <= wr_data[`BIT_QUICK_SLEEP];
         lane_sleep_mask <= wr_data[`LANE_SLEEP_HI:`LANE_SLEEP_LO];
         output_disable  <= wr_data[`BIT_OUT_DISABLE];
         chip_sleep      <= wr_data[`BIT_CHIP_SLEEP];
      end
   end

   always_ff @(posedge clk) begin
      if (bank_rst) begin
         pattern_mode           <= adc_cfg_pkg::PAT_NORMAL;
         average_enable         <= 1'b0;
         output_pair_sleep_mask <= `RST_LANE_MASK;
      end else if (gp_write && wr_addr == `ADDR_PATTERN) begin
         pattern_mode <= adc_cfg_pkg::pattern_mode_t'(wr_data[`PATTERN_HI:`PATTERN_LO]);
         average_enable         <= wr_data[`BIT_AVERAGE];
         output_pair_sleep_mask <= wr_data[`PAIR_SLEEP_HI:`PAIR_SLEEP_LO];
      end
   end

   always_ff @(posedge clk) begin
      if (bank_rst) begin
         serializer_factor <= `RST_SER_FACTOR;
         gain_enable       <= 1'b0;
         offset_enable     <= 1'b0;
      end else if (gp_write && wr_addr == `ADDR_SERIALIZER) begin
         serializer_factor <= wr_data[`SER_FACTOR_HI:`SER_FACTOR_LO];
         gain_enable       <= wr_data[`BIT_GAIN_EN];
         offset_enable     <= wr_data[`BIT_OFFSET_EN];
      end
   end

   always_ff @(posedge clk) begin
      if (bank_rst) begin
         number_coding_select <= 1'b0;
         user_word            <= `RST_USER_WORD;
      end else if (gp_write && wr_addr == `ADDR_FORMAT) begin
         number_coding_select <= wr_data[`BIT_CODING];
      end else if (gp_write && wr_addr == `ADDR_USER_WORD) begin
         user_word <= wr_data[`USER_WORD_HI:`USER_WORD_LO];
      end
   end

   always_ff @(posedge clk) begin
      if (bank_rst) begin
         low_noise_mode          <= 1'b0;
         self_test_level         <= `RST_TWO_BITS;
         antialias_corner_select <= `RST_TWO_BITS;
         coupling_stored         <= 1'b0;
      end else if (gp_write && wr_addr == `ADDR_FRONT_END) begin
         low_noise_mode          <= wr_data[`BIT_LOW_NOISE];
         self_test_level         <= wr_data[`SELF_TEST_HI:`SELF_TEST_LO];
         antialias_corner_select <= wr_data[`ANTIALIAS_HI:`ANTIALIAS_LO];
         coupling_stored         <= wr_data[`BIT_COUPLING];
      end
   end

   // Stored value is kept untouched, so leaving self-test restores it
   always_ff @(posedge clk) begin
      if (bank_rst) begin
         coupling_select <= 1'b0;
         bits_per_sample <= 5'h0C;
      end else begin
         coupling_select <= self_test_level[0] | coupling_stored;
         unique case (serializer_factor)
            2'b00: bits_per_sample <= 5'h0C;
            2'b01: bits_per_sample <= 5'h0A;
            2'b10: bits_per_sample <= 5'h10;
            2'b11: bits_per_sample <= 5'h0E;
         endcase
      end
   end

   function automatic logic [11:0] sat12(input logic signed [14:0] x);
      if (x > 15'sd2047) begin
         sat12 = 12'h7FF;
      end else if (x < -15'sd2048) begin
         sat12 = 12'h800;
      end else begin
         sat12 = x[11:0];
      end
   endfunction : sat12

   // Gain is linear 1 + code/32, close to 0.2 dB steps up to 6 dB
   always_comb begin
      v_offset = {{2{sample_data[11]}}, sample_data}
                 - (offset_enable ? {6'h00, offset_value} : 14'h0000);
      v_gain_full = v_offset * $signed({2'b01, gain_code});
      v_gain = gain_enable ? v_gain_full[18:5] : v_offset;
      v_avg = average_enable ? 15'((16'(v_gain) + 16'(held_sample)) >>> 1)
                             : 15'(v_gain);
      v_sat = sat12(v_avg);
      normal_word = {v_sat[11] ^ number_coding_select, v_sat[10:0], 2'b00};
   end

   always_comb begin
      unique case (pattern_mode)
         adc_cfg_pkg::PAT_NORMAL: next_lane_word = normal_word;
         adc_cfg_pkg::PAT_SYNC:   next_lane_word = `SYNC_WORD;
         adc_cfg_pkg::PAT_DESKEW: next_lane_word = `DESKEW_WORD;
         adc_cfg_pkg::PAT_CUSTOM: next_lane_word = user_word;
         adc_cfg_pkg::PAT_ONES:   next_lane_word = `ONES_WORD;
         adc_cfg_pkg::PAT_TOGGLE: next_lane_word = toggle_phase ? `TOGGLE_WORD_B
                                                                : `TOGGLE_WORD_A;
         adc_cfg_pkg::PAT_ZEROS:  next_lane_word = `ZERO_WORD;
         adc_cfg_pkg::PAT_RAMP:   next_lane_word = ramp_count;
      endcase
      if (lane_sleep_mask[sample_chan] || output_pair_sleep_mask[sample_chan]
          || output_disable) begin
         next_lane_word = `ZERO_WORD;
      end
   end

   // Sample path keeps running through register changes and pin or software resets
   always_ff @(posedge clk) begin
      if (srst) begin
         lane_valid   <= 1'b0;
         lane_chan    <= 3'h0;
         lane_word    <= `ZERO_WORD;
         held_sample  <= '0;
         ramp_count   <= 14'h0000;
         toggle_phase <= 1'b0;
      end else begin
         lane_valid <= sample_valid;
         if (sample_valid) begin
            lane_chan    <= sample_chan;
            lane_word    <= next_lane_word;
            held_sample  <= v_gain;
            ramp_count   <= ramp_count + 14'h0001;
            toggle_phase <= ~toggle_phase;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         lane_pair_enable <= 8'h00;
      end else begin
         lane_pair_enable <= ~output_pair_sleep_mask & {8{~output_disable}};
      end
   end

   property p_soft_reset_clears;
      @(posedge clk) disable iff (srst)
      soft_rst |=> !chip_sleep && !quick_sleep && (user_word == 14'h0000) && !soft_rst;
   endproperty
   a_soft_reset_clears: assert property (p_soft_reset_clears) else $error("soft reset left state");

   property p_power_write;
      @(posedge clk) disable iff (srst)
      (wr_valid && !curve_bank_select && wr_addr == 8'h01 && !hw_rst_filt && !soft_rst)
      |=> (chip_sleep == $past(wr_data[0])) && (quick_sleep == $past(wr_data[10]))
          && (lane_sleep_mask == $past(wr_data[9:2]));
   endproperty
   a_power_write: assert property (p_power_write) else $error("power write lost");

   property p_bank_blocks;
      @(posedge clk) disable iff (srst)
      (wr_valid && curve_bank_select && wr_addr == 8'h05 && !hw_rst_filt && !soft_rst)
      |=> $stable(user_word);
   endproperty
   a_bank_blocks: assert property (p_bank_blocks) else $error("write leaked past bank select");

   property p_self_test_coupling;
      @(posedge clk) disable iff (bank_rst)
      self_test_level[0] ##1 self_test_level[0] |-> coupling_select;
   endproperty
   a_self_test_coupling: assert property (p_self_test_coupling) else $error("coupling not forced");

   property p_coupling_restore;
      @(posedge clk) disable iff (bank_rst)
      (!self_test_level[0]) [*2] |-> (coupling_select == $past(coupling_stored));
   endproperty
   a_coupling_restore: assert property (p_coupling_restore) else $error("coupling not restored");

   property p_custom_word;
      @(posedge clk) disable iff (srst)
      (sample_valid && pattern_mode == adc_cfg_pkg::PAT_CUSTOM && !output_disable
       && !lane_sleep_mask[sample_chan] && !output_pair_sleep_mask[sample_chan])
      |=> lane_word == $past(user_word);
   endproperty
   a_custom_word: assert property (p_custom_word) else $error("custom word not sent");

   property p_lane_sleep_zero;
      @(posedge clk) disable iff (srst)
      (sample_valid && lane_sleep_mask[sample_chan]) |=> lane_valid && lane_word == 14'h0000;
   endproperty
   a_lane_sleep_zero: assert property (p_lane_sleep_zero) else $error("slept channel not zero");

   property p_disable_pairs;
      @(posedge clk) disable iff (srst)
      output_disable ##1 output_disable |-> lane_pair_enable == 8'h00;
   endproperty
   a_disable_pairs: assert property (p_disable_pairs) else $error("outputs not disabled");

   property p_ser_factor;
      @(posedge clk) disable iff (bank_rst)
      (serializer_factor == 2'b10) [*2] |-> bits_per_sample == 5'h10;
   endproperty
   a_ser_factor: assert property (p_ser_factor) else $error("serialization factor wrong");

endmodule : adc_output_config_bank
`default_nettype wire

/* File: adc_cfg_defs.svh */
// Register offsets, field positions, reset values and pattern words
// Assumes inclusion by bare name from the register bank design files
`ifndef ADC_CFG_DEFS_SVH
`define ADC_CFG_DEFS_SVH

// Serial write word
`define WORD_BITS        24
`define ADDR_BITS        8
`define DATA_BITS        16
`define BIT_CNT_LAST     5'h17

// Register offsets
`define ADDR_BANK_CTRL   8'h00
`define ADDR_POWER_OUT   8'h01
`define ADDR_PATTERN     8'h02
`define ADDR_SERIALIZER  8'h03
`define ADDR_FORMAT      8'h04
`define ADDR_USER_WORD   8'h05
`define ADDR_FRONT_END   8'h07

// Address 0 fields
`define BIT_SOFT_RESET   0
`define BIT_CURVE_BANK   2
// Address 1 fields
`define BIT_QUICK_SLEEP  10
`define LANE_SLEEP_HI    9
`define LANE_SLEEP_LO    2
`define BIT_OUT_DISABLE  1
`define BIT_CHIP_SLEEP   0
// Address 2 fields
`define PATTERN_HI       15
`define PATTERN_LO       13
`define BIT_AVERAGE      11
`define PAIR_SLEEP_HI    10
`define PAIR_SLEEP_LO    3
// Address 3 fields
`define SER_FACTOR_HI    14
`define SER_FACTOR_LO    13
`define BIT_GAIN_EN      12
`define BIT_OFFSET_EN    8
// Address 4 fields
`define BIT_CODING       3
// Address 5 fields
`define USER_WORD_HI     13
`define USER_WORD_LO     0
// Address 7 fields
`define BIT_LOW_NOISE    10
`define SELF_TEST_HI     8
`define SELF_TEST_LO     7
`define ANTIALIAS_HI     3
`define ANTIALIAS_LO     2
`define BIT_COUPLING     1

// Reset values
`define RST_LANE_MASK    8'h00
`define RST_PATTERN      3'h0
`define RST_SER_FACTOR   2'h0
`define RST_USER_WORD    14'h0000
`define RST_TWO_BITS     2'h0

// Pattern words
`define SYNC_WORD        14'h3F80
`define DESKEW_WORD      14'h2AAA
`define TOGGLE_WORD_A    14'h2AAA
`define TOGGLE_WORD_B    14'h1555
`define ONES_WORD        14'h3FFF
`define ZERO_WORD        14'h0000

`endif

/* File: adc_cfg_pkg.sv */
// Types shared by the configuration bank and its test bench
// Assumes nothing beyond a SystemVerilog compiler
package adc_cfg_pkg;

   typedef enum logic [2:0] {
      PAT_NORMAL = 3'b000,
      PAT_SYNC   = 3'b001,
      PAT_DESKEW = 3'b010,
      PAT_CUSTOM = 3'b011,
      PAT_ONES   = 3'b100,
      PAT_TOGGLE = 3'b101,
      PAT_ZEROS  = 3'b110,
      PAT_RAMP   = 3'b111
   } pattern_mode_t;

   typedef logic [13:0] lane_word_t;

endpackage : adc_cfg_pkg

/* File: serial_write_rx.sv */
// Three-wire serial write receiver: 8-bit address then 16 data bits
// Assumes pins asynchronous to clk and serial clock well below clk/4
`timescale 1ns/100ps
`default_nettype none
`include "adc_cfg_defs.svh"

module serial_write_rx (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    srst,
   // Serial pins
   input  wire logic                    serial_clk,
   input  wire logic                    serial_select_n,
   input  wire logic                    serial_in,
   // Decoded writes
   output logic                         wr_valid,
   output logic [`ADDR_BITS-1:0]        wr_addr,
   output logic [`DATA_BITS-1:0]        wr_data
);

   logic [2:0]              sync1;
   logic [2:0]              sync2;
   logic [2:0]              sync3;
   logic [2:0]              pin_filt;
   logic                    sclk_prev;
   logic [4:0]              bit_count;
   logic [`WORD_BITS-2:0]   shift;
   logic                    sclk_rise;
   logic [`WORD_BITS-1:0]   next_word;

   // Three stages; bit 1 (select) idles high
   always_ff @(posedge clk) begin
      if (srst) begin
         sync1 <= 3'h2;
         sync2 <= 3'h2;
         sync3 <= 3'h2;
      end else begin
         sync1 <= {serial_in, serial_select_n, serial_clk};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // A level counts once the second and third stage agree
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_filt
         always_ff @(posedge clk) begin
            if (srst) begin
               pin_filt[gi] <= (gi == 1);
            end else if (sync2[gi] == sync3[gi]) begin
               pin_filt[gi] <= sync3[gi];
            end
         end
      end
   endgenerate

   assign sclk_rise = pin_filt[0] & ~sclk_prev;
   assign next_word = {shift, pin_filt[2]};

   always_ff @(posedge clk) begin
      if (srst) begin
         sclk_prev <= 1'b0;
      end else begin
         sclk_prev <= pin_filt[0];
      end
   end

   // Partial word dropped when select rises
   always_ff @(posedge clk) begin
      if (srst || pin_filt[1]) begin
         bit_count <= 5'h00;
         shift     <= '0;
      end else if (sclk_rise) begin
         shift     <= next_word[`WORD_BITS-2:0];
         bit_count <= (bit_count == `BIT_CNT_LAST) ? 5'h00 : bit_count + 5'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wr_valid <= 1'b0;
         wr_addr  <= '0;
         wr_data  <= '0;
      end else begin
         wr_valid <= sclk_rise && !pin_filt[1] && (bit_count == `BIT_CNT_LAST);
         if (sclk_rise && !pin_filt[1] && (bit_count == `BIT_CNT_LAST)) begin
            wr_addr <= next_word[`WORD_BITS-1:`DATA_BITS];
            wr_data <= next_word[`DATA_BITS-1:0];
         end
      end
   end

   property p_word_len;
      @(posedge clk) disable iff (srst)
      wr_valid |-> ($past(bit_count) == `BIT_CNT_LAST) && (bit_count == 5'h00);
   endproperty
   a_word_len: assert property (p_word_len) else $error("write without 24 bits");

endmodule : serial_write_rx
`default_nettype wire

/* File: serial_host.sv */
// Host model that drives the three-wire serial write pins
// Assumes the bench clock; between writes sclk and sdi are driven low and sel_n high
`timescale 1ns/100ps
`default_nettype none

module serial_host (
   // Bench clock
   input  wire logic clk,
   // Serial pins
   output logic      sclk,
   output logic      sel_n,
   output logic      sdi
);
   initial begin
      sclk = 1'b0;
      sel_n = 1'b1;
      sdi = 1'b0;
   end

   task automatic hw(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : hw

   // Ten clocks low and five high per bit keeps sclk below the receiver's limit
   task automatic send(input logic [23:0] w, input int nb);
      hw(1);
      sel_n = 1'b0;
      for (int i = 0; i < nb; i++) begin
         hw(5);
         sdi = w[23-i];
         hw(5);
         sclk = 1'b1;
         hw(5);
         sclk = 1'b0;
      end
      hw(5);
      sel_n = 1'b1;
      sdi = 1'b0;
   endtask : send
endmodule : serial_host

`default_nettype wire

/* File: adc_output_config_bank_test.sv */
// Self-checking bench for the output configuration bank
// Assumes serial_host as the programming host; samples driven here
`timescale 1ns/100ps
`default_nettype none

module adc_output_config_bank_test;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        hw_pin = 1'b0;
   logic        sv = 1'b0;
   logic [2:0]  sch = 3'h0;
   logic [11:0] sd = 12'h000;
   logic [11:0] d;
   logic [4:0]  gain = 5'h00;
   logic [7:0]  off = 8'h00;
   logic        sclk, sel_n, sdi, qs, cs, cbs, ln, cpl, lv;
   logic [7:0]  lsm, lpe;
   logic [1:0]  stl, acs, sf;
   logic [4:0]  bps;
   logic [2:0]  lch;
   logic [13:0] lw;
   int          n_fail = 0;
   int          tests_run = 0;
   int          seed = 86;
   logic [16:0] exp_q[$];
   logic [16:0] note;
   logic signed [12:0] acc;
   int          ns = 0;
   adc_cfg_pkg::lane_word_t pw[8];
   logic [4:0]  bps_tab[4] = '{5'h0C, 5'h0A, 5'h10, 5'h0E};

   always #25 clk = ~clk;

   serial_host host_u (.clk(clk), .sclk(sclk), .sel_n(sel_n), .sdi(sdi));

   adc_output_config_bank dut_u (
      .clk(clk), .srst(srst), .hw_reset_pin(hw_pin), .serial_clk(sclk),
      .serial_select_n(sel_n), .serial_in(sdi), .sample_valid(sv),
      .sample_chan(sch), .sample_data(sd), .gain_code(gain),
      .offset_value(off), .quick_sleep(qs), .lane_sleep_mask(lsm),
      .chip_sleep(cs), .curve_bank_select(cbs), .low_noise_mode(ln),
      .self_test_level(stl), .antialias_corner_select(acs),
      .coupling_select(cpl), .serializer_factor(sf), .bits_per_sample(bps),
      .lane_valid(lv), .lane_chan(lch), .lane_word(lw), .lane_pair_enable(lpe));

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      host_u.send({a, v}, 24);
      cyc(12);
   endtask : wr

   task automatic samp(input logic [2:0] c, input logic [11:0] v, input logic [13:0] e);
      sch = c;
      sd = v;
      sv = 1'b1;
      exp_q.push_back({c, e});
      ns++;
      cyc(1);
      sv = 1'b0;
      cyc(3);
   endtask : samp

   // Each lane result is matched against the oldest expectation
   always @(posedge clk) begin
      if (lv === 1'b1) begin
         if (exp_q.size() == 0)
            chk("lane_valid", 16'h0000, 16'h0001);
         else begin
            note = exp_q.pop_front();
            chk("lane_chan", 16'(note[16:14]), 16'(lch));
            chk("lane_word", 16'(note[13:0]), 16'(lw));
         end
      end
   end

   initial begin
      cyc(50000);
      chk("timeout", 16'h0000, 16'h0001);
      end_sim();
   end

   initial begin
      cyc(5);
      srst = 1'b0;
      cyc(4);
      chk("bits_per_sample", 16'h000C, 16'(bps));
      chk("lane_pair_enable", 16'h00FF, 16'(lpe));
      wr(8'h01, 16'h0421);
      chk("quick_sleep", 16'h0001, 16'(qs));
      chk("lane_sleep_mask", 16'h0008, 16'(lsm));
      chk("chip_sleep", 16'h0001, 16'(cs));
      wr(8'h01, 16'h0020);
      d = 12'($random(seed));
      samp(3'h3, d, 14'h0000);
      samp(3'h2, d, {d, 2'b00});
      gain = 5'h10;
      off = 8'h14;
      wr(8'h03, 16'h1100);
      samp(3'h2, 12'h064, {12'h078, 2'b00});
      wr(8'h03, 16'h0000);
      samp(3'h2, 12'h064, {12'h064, 2'b00});
      for (int k = 0; k < 4; k++) begin
         wr(8'h03, {1'b0, 2'(k), 13'h0000});
         chk("serializer_factor", 16'(k), 16'(sf));
         chk("bits_per_sample", 16'(bps_tab[k]), 16'(bps));
      end
      // Bank select set: the format write must be refused
      wr(8'h00, 16'h0004);
      wr(8'h04, 16'h0008);
      chk("curve_bank_select", 16'h0001, 16'(cbs));
      samp(3'h2, d, {d, 2'b00});
      wr(8'h00, 16'h0000);
      wr(8'h04, 16'h0008);
      samp(3'h2, d, {~d[11], d[10:0], 2'b00});
      wr(8'h02, 16'h02D0);
      chk("lane_pair_enable", 16'h00A5, 16'(lpe));
      wr(8'h01, 16'h0002);
      chk("lane_pair_enable", 16'h0000, 16'(lpe));
      samp(3'h0, d, 14'h0000);
      wr(8'h01, 16'h0000);
      pw[3] = 14'($random(seed));
      pw[1] = 14'h3F80;
      pw[2] = 14'h2AAA;
      pw[4] = 14'h3FFF;
      pw[6] = 14'h0000;
      wr(8'h05, {2'b00, pw[3]});
      // Toggle phase and ramp both advance once per sample since reset
      for (int k = 1; k < 8; k++) begin
         pw[5] = ns[0] ? 14'h1555 : 14'h2AAA;
         pw[7] = 14'(ns);
         wr(8'h02, {3'(k), 13'h0000});
         samp(3'h1, d, pw[k]);
      end
      wr(8'h07, 16'h0488);
      chk("low_noise_mode", 16'h0001, 16'(ln));
      chk("self_test_level", 16'h0001, 16'(stl));
      chk("antialias_corner_select", 16'h0002, 16'(acs));
      chk("coupling_select", 16'h0001, 16'(cpl));
      wr(8'h07, 16'h0408);
      chk("coupling_select", 16'h0000, 16'(cpl));
      chk("self_test_level", 16'h0000, 16'(stl));
      wr(8'h07, 16'h0402);
      chk("coupling_select", 16'h0001, 16'(cpl));
      // Half a word, which would clear the noise mode if taken
      host_u.send(24'h070000, 12);
      cyc(12);
      chk("low_noise_mode", 16'h0001, 16'(ln));
      wr(8'h00, 16'h0001);
      chk("low_noise_mode", 16'h0000, 16'(ln));
      chk("antialias_corner_select", 16'h0000, 16'(acs));
      wr(8'h07, 16'h0400);
      chk("low_noise_mode", 16'h0001, 16'(ln));
      hw_pin = 1'b1;
      cyc(5);
      hw_pin = 1'b0;
      cyc(8);
      chk("low_noise_mode", 16'h0000, 16'(ln));
      // Averaging pairs with the previous sample, here the last ramp one
      wr(8'h02, 16'h0800);
      acc = $signed({d[11], d}) + 13'sh0100;
      samp(3'h2, 12'h100, {acc[12:1], 2'b00});
      samp(3'h2, 12'h040, {12'h0A0, 2'b00});
      for (int i = 0; i < 20 && exp_q.size() != 0; i++)
         cyc(1);
      chk("pending_words", 16'h0000, 16'(exp_q.size()));
      end_sim();
   end
endmodule : adc_output_config_bank_test

`default_nettype wire
